// File: src/tsnw_top.sv
// Terminal status notify word: keeps the status word in host memory current
//
// Summary of operation
// - Run mode drives status bit 15 high.
// - Any other mode or menu: bit 15 low.
// - Bit 15 low: no host memory access.
// - In run, periodically rewrite bit 15 high.
// - Host zeroed bit restored within 30 seconds.
// - Screen change sets bit 12, cleared after notify.
// - Numeral entry sets bit 11, cleared after notify.
// - In run, write word whenever reported status changes.
//
// The address map and the Wishbone register port were left to the implementer.
module tsnw_top #(
   parameter longint unsigned REFRESH_CYCLES  = tsnw_pkg::REFRESH_CYCLES,
   parameter longint unsigned LIVENESS_CYCLES = tsnw_pkg::LIVENESS_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Classic Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Display events from terminal logic, one-cycle pulses
   input  wire logic        screen_changed,
   input  wire logic        numeral_entered,
   // Host memory write port
   output logic             host_wr_req,
   output logic [15:0]      host_wr_data,
   input  wire logic        host_wr_ack
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks
   // Refused at elaboration, not at run time
   if (REFRESH_CYCLES < 64'd2 || REFRESH_CYCLES > 64'hFFFF_FFFF) begin : g_bad_refresh
      $error("REFRESH_CYCLES out of range");
   end
   if (REFRESH_CYCLES >= LIVENESS_CYCLES) begin : g_bad_liveness
      $error("refresh period must be shorter than the liveness window");
   end

   localparam logic [31:0] REFRESH_LAST = 32'(REFRESH_CYCLES - 64'd1);

   function automatic logic [15:0] build_word(input logic run, input logic scr, input logic num);
      logic [15:0] w;
      w                         = 16'h0000;
      w[tsnw_pkg::RUN_BIT]      = run;
      w[tsnw_pkg::SCREEN_BIT]   = scr;
      w[tsnw_pkg::NUMERAL_BIT]  = num;
      return w;
   endfunction : build_word

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave
   logic        ack_q;
   logic        ack_d;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;
   logic        run_mode_q;
   logic        run_mode_d;
   logic        menu_q;
   logic        menu_d;
   logic        sw_scr_evt;
   logic        sw_num_evt;
   logic        bus_req;
   logic        scr_pend_q;
   logic        num_pend_q;
   logic [15:0] sent_q;
   logic        wr_busy;

   assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;

   always_comb begin
      ack_d      = bus_req;
      rdat_d     = 32'h0000_0000;
      run_mode_d = run_mode_q;
      menu_d     = menu_q;
      sw_scr_evt = 1'b0;
      sw_num_evt = 1'b0;
      if (bus_req) begin
         if (wb_adr_i == tsnw_pkg::CTRL_OFS) begin
            rdat_d[tsnw_pkg::CTRL_RUN_BIT]  = run_mode_q;
            rdat_d[tsnw_pkg::CTRL_MENU_BIT] = menu_q;
            if (wb_we_i && wb_sel_i[0]) begin
               run_mode_d = wb_dat_i[tsnw_pkg::CTRL_RUN_BIT];
               menu_d     = wb_dat_i[tsnw_pkg::CTRL_MENU_BIT];
            end
         end else if (wb_adr_i == tsnw_pkg::EVENT_OFS) begin
            if (wb_we_i && wb_sel_i[0]) begin
               sw_scr_evt = wb_dat_i[tsnw_pkg::EVT_SCREEN_BIT];
               sw_num_evt = wb_dat_i[tsnw_pkg::EVT_NUMERAL_BIT];
            end
         end else if (wb_adr_i == tsnw_pkg::SENT_OFS) begin
            rdat_d[15:0] = sent_q;
         end else if (wb_adr_i == tsnw_pkg::PEND_OFS) begin
            rdat_d[tsnw_pkg::PEND_SCREEN_BIT]  = scr_pend_q;
            rdat_d[tsnw_pkg::PEND_NUMERAL_BIT] = num_pend_q;
            rdat_d[tsnw_pkg::PEND_BUSY_BIT]    = wr_busy;
         end else begin
            // Unmapped: acknowledged, reads zero, writes dropped
            rdat_d = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ack_q      <= 1'b0;
         rdat_q     <= 32'h0000_0000;
         run_mode_q <= tsnw_pkg::CTRL_RESET;
         menu_q     <= tsnw_pkg::CTRL_RESET;
      end else begin
         ack_q      <= ack_d;
         rdat_q     <= rdat_d;
         run_mode_q <= run_mode_d;
         menu_q     <= menu_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   ////////////////////////////////////////////////////////////////////////////
   // Status word state
   logic        running;
   logic        scr_pend_d;
   logic        num_pend_d;
   logic [15:0] sent_d;
   logic [31:0] refresh_q;
   logic [31:0] refresh_d;
   logic        refresh_due_q;
   logic        refresh_due_d;
   logic [15:0] cur_word;
   logic        wr_start;
   logic        wr_done;
   logic        scr_evt;
   logic        num_evt;

   assign running = run_mode_q && !menu_q;
   assign scr_evt = screen_changed || sw_scr_evt;
   assign num_evt = numeral_entered || sw_num_evt;
   assign cur_word = build_word(running, scr_pend_q, num_pend_q);

   // A change or a due refresh starts a write; never while stopped
   assign wr_start = running && !wr_busy && ((cur_word != sent_q) || refresh_due_q);

   always_comb begin
      scr_pend_d    = scr_pend_q;
      num_pend_d    = num_pend_q;
      sent_d        = sent_q;
      refresh_d     = refresh_q;
      refresh_due_d = refresh_due_q;
      if (!running) begin
         // Stopped: events are not reported and the next run writes afresh
         scr_pend_d    = 1'b0;
         num_pend_d    = 1'b0;
         sent_d        = tsnw_pkg::WORD_RESET;
         refresh_d     = 32'h0000_0000;
         refresh_due_d = 1'b0;
      end else begin
         if (wr_done && host_wr_data[tsnw_pkg::SCREEN_BIT]) begin
            scr_pend_d = 1'b0;
         end
         if (wr_done && host_wr_data[tsnw_pkg::NUMERAL_BIT]) begin
            num_pend_d = 1'b0;
         end
         // Set wins over the clear of the same cycle
         if (scr_evt) begin
            scr_pend_d = 1'b1;
         end
         if (num_evt) begin
            num_pend_d = 1'b1;
         end
         if (wr_done) begin
            sent_d = host_wr_data;
         end
         if (wr_start) begin
            refresh_d     = 32'h0000_0000;
            refresh_due_d = 1'b0;
         end else if (refresh_q == REFRESH_LAST) begin
            refresh_due_d = 1'b1;
         end else begin
            refresh_d = refresh_q + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scr_pend_q    <= 1'b0;
         num_pend_q    <= 1'b0;
         sent_q        <= tsnw_pkg::WORD_RESET;
         refresh_q     <= 32'h0000_0000;
         refresh_due_q <= 1'b0;
      end else begin
         scr_pend_q    <= scr_pend_d;
         num_pend_q    <= num_pend_d;
         sent_q        <= sent_d;
         refresh_q     <= refresh_d;
         refresh_due_q <= refresh_due_d;
      end
   end

   tsnw_writer u_writer (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .start        (wr_start),
      .word         (cur_word),
      .host_wr_ack  (host_wr_ack),
      .host_wr_req  (host_wr_req),
      .host_wr_data (host_wr_data),
      .busy         (wr_busy),
      .done         (wr_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   logic [31:0] gap_q;

   // Idle cycles since the last write ended while running
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gap_q <= 32'h0000_0000;
      end else if (!running || wr_start || wr_busy) begin
         gap_q <= 32'h0000_0000;
      end else begin
         gap_q <= gap_q + 32'h0000_0001;
      end
   end

   sequence s_scr_event;
      running && scr_evt;
   endsequence

   sequence s_scr_sent;
      wr_done && host_wr_data[tsnw_pkg::SCREEN_BIT] && !scr_evt;
   endsequence

   chk_run_bit_set: assert property (@(posedge clk) disable iff (sys_rst)
      host_wr_req |-> host_wr_data[tsnw_pkg::RUN_BIT])
      else $error("run bit written low");

   chk_stop_bit_clear: assert property (@(posedge clk) disable iff (sys_rst)
      (!run_mode_q || menu_q) |-> !cur_word[tsnw_pkg::RUN_BIT])
      else $error("run bit high outside run mode");

   chk_stop_no_access: assert property (@(posedge clk) disable iff (sys_rst)
      (!running && !wr_busy) |-> !wr_start ##1 !host_wr_req)
      else $error("host memory access while stopped");

   chk_refresh_bound: assert property (@(posedge clk) disable iff (sys_rst)
      64'(gap_q) <= REFRESH_CYCLES)
      else $error("periodic rewrite overdue");

   chk_liveness_window: assert property (@(posedge clk) disable iff (sys_rst)
      64'(gap_q) < LIVENESS_CYCLES)
      else $error("run bit not restored within liveness window");

   chk_screen_strobe: assert property (@(posedge clk) disable iff (sys_rst)
      s_scr_event |=> scr_pend_q ##0 (cur_word[tsnw_pkg::SCREEN_BIT] || !running))
      else $error("screen change not flagged");

   chk_screen_clear: assert property (@(posedge clk) disable iff (sys_rst)
      s_scr_sent |=> !scr_pend_q)
      else $error("screen strobe not cleared after notify");

   chk_numeral_strobe: assert property (@(posedge clk) disable iff (sys_rst)
      running && num_evt |=> num_pend_q)
      else $error("numeral entry not flagged");

   chk_numeral_clear: assert property (@(posedge clk) disable iff (sys_rst)
      wr_done && host_wr_data[tsnw_pkg::NUMERAL_BIT] && !num_evt && running |=> !num_pend_q)
      else $error("numeral strobe not cleared after notify");

   chk_change_write: assert property (@(posedge clk) disable iff (sys_rst)
      running && !wr_busy && (cur_word != sent_q) |=> host_wr_req && host_wr_data == $past(cur_word))
      else $error("status change not written");

   chk_zero_bits: assert property (@(posedge clk) disable iff (sys_rst)
      host_wr_req |-> host_wr_data[14:13] == 2'h0 && host_wr_data[10:0] == 11'h000)
      else $error("unused status bits written nonzero");

   chk_bus_ack_once: assert property (@(posedge clk) disable iff (sys_rst)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held for two cycles");

   chk_bus_ack_timing: assert property (@(posedge clk) disable iff (sys_rst)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not acknowledged next cycle");

   chk_stop_pend_clear: assert property (@(posedge clk) disable iff (sys_rst)
      !running |=> !scr_pend_q && !num_pend_q)
      else $error("strobe kept pending while stopped");

endmodule : tsnw_top

// File: src/tsnw_pkg.sv
// Constants shared by the terminal status notify word logic
package tsnw_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Status word layout
   localparam int unsigned WORD_W      = 16;
   localparam int unsigned RUN_BIT     = 15;
   localparam int unsigned SCREEN_BIT  = 12;
   localparam int unsigned NUMERAL_BIT = 11;
   localparam logic [15:0] WORD_RESET  = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses
   localparam logic [3:0] CTRL_OFS   = 4'h0;
   localparam logic [3:0] EVENT_OFS  = 4'h4;
   localparam logic [3:0] SENT_OFS   = 4'h8;
   localparam logic [3:0] PEND_OFS   = 4'hC;

   // CTRL fields
   localparam int unsigned CTRL_RUN_BIT  = 0;
   localparam int unsigned CTRL_MENU_BIT = 1;
   localparam logic        CTRL_RESET    = 1'b0;
   // EVENT fields, write one to raise
   localparam int unsigned EVT_SCREEN_BIT  = 0;
   localparam int unsigned EVT_NUMERAL_BIT = 1;
   // PEND fields
   localparam int unsigned PEND_SCREEN_BIT  = 0;
   localparam int unsigned PEND_NUMERAL_BIT = 1;
   localparam int unsigned PEND_BUSY_BIT    = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam longint unsigned CLK_HZ          = 64'd20_000_000;
   localparam longint unsigned REFRESH_MS      = 64'd10_000;
   localparam longint unsigned LIVENESS_MS     = 64'd30_000;
   // Longest times, rounded down
   localparam longint unsigned REFRESH_CYCLES  = (REFRESH_MS * CLK_HZ) / 64'd1000;
   localparam longint unsigned LIVENESS_CYCLES = (LIVENESS_MS * CLK_HZ) / 64'd1000;

endpackage : tsnw_pkg

// File: src/tsnw_writer.sv
// Host memory write handshake for one status word
module tsnw_writer (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        start,
   input  wire logic [15:0] word,
   input  wire logic        host_wr_ack,
   output logic             host_wr_req,
   output logic [15:0]      host_wr_data,
   output logic             busy,
   output logic             done
);

   typedef enum logic {TSNW_IDLE, TSNW_WAIT} tsnw_wstate_t;

   tsnw_wstate_t state_q;
   tsnw_wstate_t state_d;
   logic [15:0]  data_q;
   logic [15:0]  data_d;

   always_comb begin
      state_d = state_q;
      data_d  = data_q;
      case (state_q)
         TSNW_IDLE: begin
            if (start) begin
               state_d = TSNW_WAIT;
               data_d  = word;
            end
         end
         TSNW_WAIT: begin
            // Word and request stay frozen until the host takes them
            if (host_wr_ack) begin
               state_d = TSNW_IDLE;
            end
         end
         default: state_d = TSNW_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= TSNW_IDLE;
         data_q  <= tsnw_pkg::WORD_RESET;
      end else begin
         state_q <= state_d;
         data_q  <= data_d;
      end
   end

   assign host_wr_req  = (state_q == TSNW_WAIT);
   assign host_wr_data = data_q;
   assign busy         = (state_q == TSNW_WAIT);
   assign done         = (state_q == TSNW_WAIT) && host_wr_ack;

   chk_req_held_stable: assert property (@(posedge clk) disable iff (sys_rst)
      host_wr_req && !host_wr_ack |=> host_wr_req && $stable(host_wr_data))
      else $error("write request dropped or changed before ack");

endmodule : tsnw_writer

// File: verification/tsnw_host_model.sv
// Host controller memory that takes status word writes
module tsnw_host_model (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        host_wr_req,
   input  wire logic [15:0] host_wr_data,
   input  wire logic [2:0]  lat,
   input  wire logic        clr_run,
   output logic             host_wr_ack,
   output logic [15:0]      mem_word
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_n;
   ////////////////////////////////////////////////////////////////////////////
   // Own word only, apart from the control word
   always @(posedge clk) begin
      if (sys_rst) begin
         host_wr_ack <= 1'b0;
         wait_n      <= 0;
         mem_word    <= 16'h0000;
      end else begin
         if (clr_run) begin
            mem_word[15] <= 1'b0;
         end
         if (host_wr_req && host_wr_ack) begin
            mem_word    <= host_wr_data;
            host_wr_ack <= 1'b0;
            wait_n      <= 0;
         end else if (host_wr_req) begin
            // Latency 0..7 cycles, set per write by the bench
            if (wait_n >= int'(lat)) begin
               host_wr_ack <= 1'b1;
            end else begin
               wait_n <= wait_n + 1;
            end
         end
      end
   end
endmodule : tsnw_host_model

// File: verification/tb_top.sv
// Self-checking bench for the status notify word block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIV = 60;
   logic        clk = 1'b0, sys_rst = 1'b1;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
   logic        wb_ack_o, screen_changed = 1'b0, numeral_entered = 1'b0;
   logic        host_wr_req, host_wr_ack, clr_run = 1'b0;
   logic [15:0] host_wr_data, mem_word, last_w = 16'h0000;
   logic [2:0]  lat = 3'h0;
   logic [7:0]  seed = 8'h4E;
   logic [15:0] got[$];
   int          failures = 0, n_checks = 0;
   always #25 clk = ~clk;
   tsnw_top #(.REFRESH_CYCLES(20), .LIVENESS_CYCLES(LIV)) dut_u (.clk(clk), .sys_rst(sys_rst),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .screen_changed(screen_changed), .numeral_entered(numeral_entered),
      .host_wr_req(host_wr_req), .host_wr_data(host_wr_data), .host_wr_ack(host_wr_ack));
   tsnw_host_model host_u (.clk(clk), .sys_rst(sys_rst), .host_wr_req(host_wr_req),
      .host_wr_data(host_wr_data), .lat(lat), .clr_run(clr_run), .host_wr_ack(host_wr_ack),
      .mem_word(mem_word));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   // Refresh rewrites repeat the last word, so only changes are queued
   always @(posedge clk) begin
      if (host_wr_req === 1'b1 && host_wr_ack === 1'b1) begin
         seed = lfsr(seed);
         lat <= seed[2:0];
         if (host_wr_data !== last_w) begin
            got.push_back(host_wr_data);
            last_w = host_wr_data;
         end
      end
   end
   task automatic end_sim;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic xfer(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, 4'hF, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      r = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      if (n >= 50) begin
         failures++;
         end_sim();
      end
   endtask : xfer
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0000_0000, r);
      chk(r, e);
   endtask : rd
   task automatic pulse(input logic [2:0] m);
      @(posedge clk);
      {clr_run, numeral_entered, screen_changed} <= m;
      @(posedge clk);
      {clr_run, numeral_entered, screen_changed} <= 3'b000;
   endtask : pulse
   task automatic wait_got(input int k);
      int n;
      for (n = 0; n < 300 && got.size() < k; n++) @(posedge clk);
      chk(got.size(), k);
      if (got.size() < k) end_sim();
   endtask : wait_got
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] e;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      rd(4'h0, 0); rd(4'h8, 0); rd(4'hC, 0); rd(4'h4, 0);
      wr(4'h2, 32'h0000_0003);
      rd(4'h2, 0);
      pulse(3'b011);
      repeat (30) @(posedge clk);
      chk(got.size(), 0);
      rd(4'hC, 0);
      $display("test stopped done");
      wr(4'h0, 32'h0000_0001);
      wait_got(1);
      chk(got.pop_front(), 32'h8000);
      rd(4'h8, 32'h8000);
      $display("test run done");
      // Pins first, then the same three events through the event register
      for (int m = 1; m < 7; m++) begin
         e = 16'h8000 | (16'(((m - 1) % 3 + 1) & 1) << 12) | (16'(((m - 1) % 3 + 1) >> 1) << 11);
         if (m < 4) pulse(3'(m));
         else wr(4'h4, 32'(m - 3));
         wait_got(2);
         chk(got.pop_front(), e);
         chk(got.pop_front(), 32'h8000);
      end
      $display("test strobes done");
      pulse(3'b100);
      repeat (LIV) @(posedge clk);
      chk(mem_word[15], 1);
      $display("test liveness done");
      wr(4'h0, 32'h0000_0003);
      rd(4'h0, 32'h0000_0003);
      repeat (10) @(posedge clk);
      got.delete();
      pulse(3'b111);
      wr(4'h4, 32'h0000_0003);
      repeat (LIV) @(posedge clk);
      chk(mem_word[15], 0);
      chk(got.size(), 0);
      wr(4'h0, 32'h0000_0001);
      last_w = 16'h0000;
      wait_got(1);
      chk(got.pop_front(), 32'h8000);
      $display("test menu done");
      end_sim();
   end
endmodule : tb_top
